// >>> hw/mcr_pkg.sv
/*
 * Constants shared by the metering configuration register bank: register
 * offsets, field positions, write masks, reset values, phase codes and the
 * soft reset timing.
 * Assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus.
 */
// What this block does
// - Config bit 0 turns the digital integrator on for all phase currents and neutral.
// - Config bit 3 swaps voltage channel outputs with current channel outputs.
// - Config bit 4 makes the voltage converters act as if their inputs were grounded.
// - Config bit 5 makes the current converters act as if their inputs were grounded.
// - Config bit 6 enables the capture port and puts its clock on the shared pin, else pulse 3.
// - Writing 1 to config bit 7 starts a software reset.
// - Bits 9:8 pick the voltage for phase A current: 00 A, 01 B, 10 C.
// - Bits 11:10 pick the voltage for phase B current: 00 B, 01 C, 10 A.
// - Bits 13:12 pick the voltage for phase C current: 00 C, 01 A, 10 B.
// - Code 11 in any voltage routing field acts exactly as code 00.
// - Config bits 2:1 and 15:14 have no effect.
// - Extended bit 0 at 0 makes the neutral rms path use the measured neutral current.
// - Extended bit 0 at 1 makes the neutral rms path use the sum of the three phase currents.
// - Extended bit 1 adds low-pass filtering to total active and reactive power.
package mcr_pkg;

  localparam logic [15:0] CFG_OFFSET = 16'he618;
  localparam logic [15:0] EXT_OFFSET = 16'he740;

  localparam int unsigned CFG_INTEG_BIT = 0;
  localparam int unsigned CFG_SWAP_BIT = 3;
  localparam int unsigned CFG_VGND_BIT = 4;
  localparam int unsigned CFG_IGND_BIT = 5;
  localparam int unsigned CFG_CAPT_BIT = 6;
  localparam int unsigned CFG_SRST_BIT = 7;
  localparam int unsigned CFG_VSEL_LSB = 8;
  localparam int unsigned EXT_NSRC_BIT = 0;
  localparam int unsigned EXT_LPF_BIT = 1;

  localparam logic [15:0] CFG_WMASK = 16'h3ff9;
  localparam logic [7:0] EXT_WMASK = 8'h03;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [7:0] EXT_RESET = 8'h00;

  localparam logic [1:0] VSEL_RESERVED = 2'h3;
  localparam logic [1:0] PHASE_A = 2'h0;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SOFT_RST_TIME_NS = 1000;
  localparam int unsigned SOFT_RST_CYCLES =
    (SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MCR_RUN = 2'b01,
    MCR_SRST = 2'b10
  } mcr_state_e;

endpackage

// >>> hw/mcr_regs.sv
/*
 * Metering configuration register bank with an AHB-Lite slave port.
 * Holds the main and extended configuration registers, drives the steering
 * levels of the metering datapath, the shared capture clock / pulse 3 pin,
 * the soft reset pulse and the neutral rms source sample.
 * Assumes a single 10 MHz clock, synchronous inputs and one bus master.
 */
`timescale 1ns/100ps
module mcr_regs
  import mcr_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 24
) (
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Response, always OKAY.
  output logic [31:0] hrdata, // Read data.
  output logic integrator_enable, // Integrator on for currents.
  output logic channel_swap, // Swap voltage and current outputs.
  output logic voltage_adc_ground, // Voltage ADCs see ground.
  output logic current_adc_ground, // Current ADCs see ground.
  output logic capture_port_enable, // Capture port enabled.
  output logic soft_reset_active, // Datapath soft reset, high while active.
  output logic [1:0] volt_sel_a, // Voltage phase paired with A current.
  output logic [1:0] volt_sel_b, // Voltage phase paired with B current.
  output logic [1:0] volt_sel_c, // Voltage phase paired with C current.
  output logic neutral_rms_source, // Neutral rms from phase sum.
  output logic power_filter_boost, // Extra power filtering.
  input wire logic capture_port_clock, // Capture port clock from port.
  input wire logic pulse_output_3, // Pulse output 3 from CF logic.
  output logic shared_pin_out, // Level on the shared pin.
  input wire logic signed [SAMPLE_W-1:0] cur_a, // Phase A current sample.
  input wire logic signed [SAMPLE_W-1:0] cur_b, // Phase B current sample.
  input wire logic signed [SAMPLE_W-1:0] cur_c, // Phase C current sample.
  input wire logic signed [SAMPLE_W-1:0] cur_n, // Neutral current sample.
  output logic signed [SAMPLE_W+1:0] neutral_rms_in // Sample fed to neutral rms.
);

  localparam logic [7:0] SRST_LOAD = 8'(SOFT_RST_CYCLES);

  logic [15:0] cfg;
  logic [7:0] ext;
  logic [15:0] next_cfg;
  logic [7:0] next_ext;
  logic wr_pend;
  logic [15:0] wr_addr;
  mcr_state_e state;
  mcr_state_e next_state;
  logic [7:0] srst_cnt;
  logic [1:0] vsel [3];

  // Address phase decode.
  wire addr_phase = hsel && hready && htrans[1];
  wire hit_cfg_a = haddr[15:2] == CFG_OFFSET[15:2];
  wire hit_ext_a = haddr[15:2] == EXT_OFFSET[15:2];
  wire [31:0] rd_mux = hit_cfg_a ? {16'h0000, cfg} :
                       hit_ext_a ? {24'h000000, ext} : 32'h00000000;

  // Data phase write decode.
  wire wr_cfg = wr_pend && (wr_addr[15:2] == CFG_OFFSET[15:2]);
  wire wr_ext = wr_pend && (wr_addr[15:2] == EXT_OFFSET[15:2]);
  wire srst_req = wr_cfg && hwdata[CFG_SRST_BIT];
  wire srst_done = (state == MCR_SRST) && (srst_cnt == 8'h01);

  // Reserved bits are masked off on write so they hold no state.
  wire [15:0] cfg_wr = hwdata[15:0] & CFG_WMASK;
  wire [7:0] ext_wr = hwdata[7:0] & EXT_WMASK;

  // A write that lands on the completion cycle wins over the self clear.
  always_comb begin
    next_cfg = cfg;
    if (srst_done) begin
      next_cfg[CFG_SRST_BIT] = 1'b0;
    end
    if (wr_cfg) begin
      next_cfg = cfg_wr;
    end
  end

  assign next_ext = wr_ext ? ext_wr : ext;

  always_comb begin
    next_state = state;
    case (state)
      MCR_RUN: begin
        if (srst_req) begin
          next_state = MCR_SRST;
        end
      end
      MCR_SRST: begin
        if (srst_done && !srst_req) begin
          next_state = MCR_RUN;
        end
      end
      default: begin
        next_state = MCR_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 16'h0000;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= addr_phase && hwrite;
      wr_addr <= haddr[15:0];
      if (addr_phase && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Zero wait states, so ready and response never move after reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= CFG_RESET;
      ext <= EXT_RESET;
    end else begin
      cfg <= next_cfg;
      ext <= next_ext;
    end
  end

  // A new request during a running soft reset restarts the count.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= MCR_RUN;
      srst_cnt <= 8'h00;
    end else begin
      state <= next_state;
      if (srst_req) begin
        srst_cnt <= SRST_LOAD;
      end else if (state == MCR_SRST && srst_cnt != 8'h00) begin
        srst_cnt <= srst_cnt - 8'h01;
      end
    end
  end

  assign soft_reset_active = state[1];
  assign integrator_enable = cfg[CFG_INTEG_BIT];
  assign channel_swap = cfg[CFG_SWAP_BIT];
  assign voltage_adc_ground = cfg[CFG_VGND_BIT];
  assign current_adc_ground = cfg[CFG_IGND_BIT];
  assign capture_port_enable = cfg[CFG_CAPT_BIT];
  assign neutral_rms_source = ext[EXT_NSRC_BIT];
  assign power_filter_boost = ext[EXT_LPF_BIT];

  // Each field is an offset from its own phase, so absolute phase is
  // (own phase + code) mod 3; code 11 collapses to 00.
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_vsel
      wire [1:0] code = cfg[CFG_VSEL_LSB + 2*p +: 2];
      wire [1:0] eff = (code == VSEL_RESERVED) ? PHASE_A : code;
      wire [2:0] sum = 3'(p) + {1'b0, eff};
      wire [1:0] abs_ph = (sum >= 3'd3) ? 2'(sum - 3'd3) : sum[1:0];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          vsel[p] <= 2'(p);
        end else begin
          vsel[p] <= abs_ph;
        end
      end
    end
  endgenerate

  assign volt_sel_a = vsel[0];
  assign volt_sel_b = vsel[1];
  assign volt_sel_c = vsel[2];

  // The pin mux is registered so the pin never sees a decode glitch;
  // this costs one cycle of delay on the capture clock and on pulse 3.
  wire pin_next = cfg[CFG_CAPT_BIT] ? capture_port_clock : pulse_output_3;

  wire signed [SAMPLE_W+1:0] phase_sum =
    (SAMPLE_W+2)'(cur_a) + (SAMPLE_W+2)'(cur_b) + (SAMPLE_W+2)'(cur_c);
  wire signed [SAMPLE_W+1:0] n_next =
    ext[EXT_NSRC_BIT] ? phase_sum : (SAMPLE_W+2)'(cur_n);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_pin_out <= 1'b0;
      neutral_rms_in <= '0;
    end else begin
      shared_pin_out <= pin_next;
      neutral_rms_in <= n_next;
    end
  end

endmodule // mcr_regs

// >>> verif/mcr_regs_props.sv
/* Assertions on the ports of the metering configuration register bank.
   Assumes one clock, async active-low reset and single word bus transfers. */
`timescale 1ns/100ps
module mcr_regs_props
  import mcr_pkg::*;
(
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset.
  input wire logic hsel, // Select.
  input wire logic [31:0] haddr, // Address.
  input wire logic [1:0] htrans, // Type.
  input wire logic hwrite, // Write.
  input wire logic [31:0] hwdata, // Data in.
  input wire logic hready, // Ready.
  input wire logic [31:0] hrdata, // Data out.
  input wire logic integrator_enable, // Bit 0.
  input wire logic channel_swap, // Bit 3.
  input wire logic voltage_adc_ground, // Bit 4.
  input wire logic current_adc_ground, // Bit 5.
  input wire logic capture_port_enable, // Bit 6.
  input wire logic soft_reset_active, // Reset run.
  input wire logic [1:0] volt_sel_a, // Route A.
  input wire logic [1:0] volt_sel_b, // Route B.
  input wire logic [1:0] volt_sel_c, // Route C.
  input wire logic neutral_rms_source, // Ext 0.
  input wire logic power_filter_boost, // Ext 1.
  input wire logic capture_port_clock, // Pin in.
  input wire logic pulse_output_3, // Pin in.
  input wire logic shared_pin_out // Pin.
);
  logic wr_cfg, wr_ext, rd_cfg;
  logic [3:0] srst_run;
  wire go = hsel && hready && htrans[1];
  wire at_cfg = haddr[15:2] == CFG_OFFSET[15:2];
  wire at_ext = haddr[15:2] == EXT_OFFSET[15:2];
  wire srw = wr_cfg && hwdata[7];
  // Data phase markers, so each property can look at hwdata in the right cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_cfg, wr_ext, rd_cfg} <= 3'h0;
    end else begin
      {wr_cfg, wr_ext, rd_cfg} <= {go && hwrite && at_cfg, go && hwrite && at_ext,
        go && !hwrite && at_cfg};
    end
  end
  // Counts the cycles of a running soft reset since its last request, so that the
  // length can be checked without unrolling a long repetition.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srst_run <= 4'h0;
    end else if (srw || !soft_reset_active) begin
      srst_run <= 4'h0;
    end else begin
      srst_run <= srst_run + 4'h1;
    end
  end
  function automatic logic [1:0] rt(input logic [1:0] b, input logic [1:0] c);
    logic [2:0] s;
    s = {1'b0, b} + {1'b0, (c == 2'h3) ? 2'h0 : c};
    rt = (s > 3'h2) ? 2'(s - 3'h3) : 2'(s);
  endfunction
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_cfg_bits: assert property (wr_cfg |=>
    {capture_port_enable, current_adc_ground, voltage_adc_ground, channel_swap,
     integrator_enable} == $past({hwdata[6:3], hwdata[0]})) else $error("config bit mismatch");
  a_srst_start: assert property (srw |=> soft_reset_active)
    else $error("soft reset did not start");
  a_srst_holds: assert property ($rose(soft_reset_active) |-> soft_reset_active[*8])
    else $error("soft reset too short");
  a_srst_ends: assert property (srst_run <= SOFT_RST_CYCLES)
    else $error("soft reset did not end");
  a_vsel_route: assert property (wr_cfg |-> ##2
    volt_sel_a == rt(2'h0, $past(hwdata[9:8], 2)) && volt_sel_b == rt(2'h1,
    $past(hwdata[11:10], 2)) && volt_sel_c == rt(2'h2, $past(hwdata[13:12], 2)))
    else $error("voltage routing mismatch");
  a_ext_bits: assert property (wr_ext |=>
    {power_filter_boost, neutral_rms_source} == $past(hwdata[1:0])) else $error("ext mismatch");
  a_reserved: assert property (rd_cfg |-> hrdata[31:14] == 18'h0 && hrdata[2:1] == 2'h0)
    else $error("reserved bits read nonzero");
  a_pin_mux: assert property ($past(hresetn) |-> shared_pin_out ==
    $past(capture_port_enable ? capture_port_clock : pulse_output_3)) else $error("pin mismatch");
endmodule // mcr_regs_props

// >>> verif/tb_top.sv
/* Directed bench for the metering configuration bank over AHB-Lite.
   Assumes the slave alone drives hready and the checker is bound below. */
`timescale 1ns/100ps
module tb_top;
  import mcr_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, capture_port_clock = 0, pulse_output_3 = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, volt_sel_a, volt_sel_b, volt_sel_c;
  logic [2:0] hsize = 3'h2;
  logic signed [23:0] cur_a = 0, cur_b = 0, cur_c = 0, cur_n = 0;
  logic signed [25:0] neutral_rms_in;
  logic hreadyout, hresp, integrator_enable, channel_swap, voltage_adc_ground;
  logic current_adc_ground, capture_port_enable, soft_reset_active, neutral_rms_source;
  logic power_filter_boost, shared_pin_out;
  wire hready = hreadyout;
  int miscompares = 0, n_checks = 0, cyc = 0;
  mcr_regs u_dut (.*);
  initial begin
    forever #50 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task finish_test;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      finish_test;
    end
  end
  initial begin
    logic [31:0] e;
    int k;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(CFG_OFFSET, 0, 0);
    chk(rd, 32'h0);
    chk({26'h0, volt_sel_c, volt_sel_b, volt_sel_a}, 32'h24);
    for (int i = 0; i < 7; i++) begin
      e = 32'h1 << i;
      xfer(CFG_OFFSET, 1, e);
      xfer(CFG_OFFSET, 0, 0);
      chk(rd, {16'h0, CFG_WMASK} & e);
      chk({27'h0, capture_port_enable, current_adc_ground, voltage_adc_ground, channel_swap,
        integrator_enable}, {27'h0, e[6:3], e[0]});
    end
    for (int c = 0; c < 4; c++) begin
      xfer(CFG_OFFSET, 1, c * 32'h1500);
      repeat (2) @(posedge hclk);
      k = (c == 3) ? 0 : c;
      chk({26'h0, volt_sel_c, volt_sel_b, volt_sel_a},
        {26'h0, 2'((k + 2) % 3), 2'((k + 1) % 3), 2'(k)});
    end
    for (int m = 0; m < 2; m++) begin
      xfer(CFG_OFFSET, 1, m << 6);
      for (int v = 0; v < 2; v++) begin
        pulse_output_3 <= v[0];
        capture_port_clock <= !v[0];
        repeat (2) @(posedge hclk);
        chk(32'(shared_pin_out), 32'(m[0] ? !v[0] : v[0]));
      end
    end
    cur_a <= 24'h000100;
    cur_b <= 24'h000200;
    cur_c <= 24'hfffc00;
    cur_n <= 24'h000055;
    for (int s = 0; s < 2; s++) begin
      xfer(EXT_OFFSET, 1, s);
      repeat (2) @(posedge hclk);
      chk(32'(neutral_rms_in), s ? 32'hffffff00 : 32'h55);
    end
    xfer(EXT_OFFSET, 1, 32'hff);
    xfer(EXT_OFFSET, 0, 0);
    chk(rd, 32'h3);
    xfer(32'h100, 1, 32'hffff);
    xfer(32'h100, 0, 0);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
    xfer(CFG_OFFSET, 1, 32'h81);
    @(posedge hclk);
    chk(32'(soft_reset_active), 32'h1);
    xfer(CFG_OFFSET, 0, 0);
    chk(rd, 32'h81);
    k = 3;
    while (soft_reset_active && k < 30) begin
      @(posedge hclk);
      k++;
    end
    chk(k, SOFT_RST_CYCLES + 1);
    xfer(CFG_OFFSET, 0, 0);
    chk(rd, 32'h1);
    finish_test;
  end
endmodule // tb_top
bind mcr_regs mcr_regs_props u_props (.*);
